//--- rtl/capture_edge.sv
`timescale 1ns/1ps
module capture_edge (
   input  wire logic   clk,
   input  wire logic   rst_n,
   input  wire logic   pin,
   edge_if.producer    ed
);
   logic sync1;
   logic sync2;
   logic last;
   // second flop isolates metastability; edge logic reads only sync2 and last
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         last  <= 1'b0;
      end else begin
         sync1 <= pin;
         sync2 <= sync1;
         last  <= sync2;
      end
   end
   assign ed.rise = sync2 & ~last;
   assign ed.fall = ~sync2 & last;
   assign ed.capture = (ed.edge_mode == ptm_pkg::FUNC_0) ? ed.rise :
                       (ed.edge_mode == ptm_pkg::FUNC_1) ? ed.fall :
                       (ed.edge_mode == ptm_pkg::FUNC_2) ? (ed.rise | ed.fall) : 1'b0;
   a_edge_single: assert property (@(posedge clk) disable iff (!rst_n)
      ed.rise |=> !ed.rise) else $error("rise pulse longer than one cycle");
endmodule // capture_edge

//--- rtl/edge_if.sv
`timescale 1ns/1ps
interface edge_if;
   logic [1:0] edge_mode;
   logic       rise;
   logic       fall;
   logic       capture;
   modport producer (input edge_mode, output rise, output fall, output capture);
   modport consumer (output edge_mode, input rise, input fall, input capture);
endinterface

//--- rtl/periodic_timer_mode_control.sv
`timescale 1ns/1ps
module periodic_timer_mode_control (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [2:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [7:0]  rdata,
   input  wire logic        timer_output_pin_in,
   output logic             timer_output_pin_out,
   output logic             timer_output_pin_oe,
   input  wire logic        timer_clock_pin
);
   logic [7:0] ctrl0;
   logic [7:0] timer_mode_output_control;
   logic [9:0] count;
   logic [9:0] duty_compare_value;
   logic [9:0] period_compare_value;
   logic [9:0] next_count;
   logic       timer_on_last;
   logic       out_level;
   logic       next_out_level;
   logic       pulse_end;
   logic       on_from_pin;

   wire [1:0] mode;
   wire [1:0] func;
   wire       timer_on;
   wire       paused;
   wire       level_cfg;
   wire       invert;
   wire       cap_src;
   wire       clr_sel;
   wire       on_rise;
   wire       match_a;
   wire       match_p;
   wire       overflow;
   wire       clear_cnt;
   wire       pwm_wave;
   wire       cap_pin;
   wire       mode_cmp;
   wire       mode_cap;
   wire       mode_pwm;
   wire       mode_tmr;
   logic      pin_level;

   edge_if ed ();

   function automatic logic is_mode(input logic [1:0] m, input logic [1:0] code);
      is_mode = (m == code);
   endfunction

   assign timer_on  = ctrl0[ptm_pkg::TIMER_ON_BIT];
   assign paused    = ctrl0[ptm_pkg::PAUSE_BIT];
   assign mode      = {timer_mode_output_control[ptm_pkg::MODE_HI_BIT],
                       timer_mode_output_control[ptm_pkg::MODE_LO_BIT]};
   assign func      = {timer_mode_output_control[ptm_pkg::FUNC_HI_BIT],
                       timer_mode_output_control[ptm_pkg::FUNC_LO_BIT]};
   assign level_cfg = timer_mode_output_control[ptm_pkg::LEVEL_BIT];
   assign invert    = timer_mode_output_control[ptm_pkg::INVERT_BIT];
   assign cap_src   = timer_mode_output_control[ptm_pkg::CAPSRC_BIT];
   assign clr_sel   = timer_mode_output_control[ptm_pkg::CLRSEL_BIT];

   assign mode_cmp = is_mode(mode, ptm_pkg::MODE_COMPARE);
   assign mode_cap = is_mode(mode, ptm_pkg::MODE_CAPTURE);
   assign mode_pwm = is_mode(mode, ptm_pkg::MODE_PWM);
   assign mode_tmr = is_mode(mode, ptm_pkg::MODE_TIMER);

   assign on_rise  = timer_on & ~timer_on_last;

   assign match_a  = timer_on && !paused && (count == duty_compare_value);
   // a zero period means no period match, so the count wraps at 1024 instead of sticking at zero
   assign match_p  = timer_on && !paused && (period_compare_value != 10'h000) && (count == period_compare_value);
   // overflow only when period is zero
   assign overflow = timer_on && !paused && (count == 10'h3ff) && (period_compare_value == 10'h000);

   // pwm and capture ignore clear select
   assign clear_cnt = (mode_cmp | mode_tmr) ? (clr_sel ? match_a : (match_p | overflow)) :
                      mode_pwm ? match_p : 1'b0;

   assign cap_pin = cap_src ? timer_clock_pin : timer_output_pin_in;

   capture_edge u_edge (
      .clk   (clk),
      .rst_n (rst_n),
      .pin   (cap_pin),
      .ed    (ed.producer)
   );
   assign ed.edge_mode = func;

   // pwm duty above period saturates to full duty
   assign pwm_wave = (count < duty_compare_value) ? level_cfg : ~level_cfg;

   always_comb begin
      next_count = count;
      if (on_rise) begin
         next_count = ptm_pkg::VALUE_RESET;
      end else if (timer_on && !paused) begin
         if (clear_cnt) begin
            next_count = ptm_pkg::VALUE_RESET;
         end else begin
            next_count = count + 10'h001;
         end
      end
   end

   always_comb begin
      next_out_level = out_level;
      if (on_rise) begin
         next_out_level = level_cfg;
      end else if (mode_cmp && match_a) begin
         case (func)
            ptm_pkg::FUNC_1: next_out_level = 1'b0;
            ptm_pkg::FUNC_2: next_out_level = 1'b1;
            ptm_pkg::FUNC_3: next_out_level = ~out_level;
            default:         next_out_level = out_level;
         endcase
      end
   end

   always_comb begin
      pin_level = out_level;
      if (mode_pwm) begin
         case (func)
            ptm_pkg::FUNC_0: pin_level = ~level_cfg;
            ptm_pkg::FUNC_1: pin_level = level_cfg;
            ptm_pkg::FUNC_2: pin_level = timer_on ? pwm_wave : ~level_cfg;
            default:         pin_level = timer_on ? level_cfg : ~level_cfg;
         endcase
      end
   end

   // single pulse ends itself on duty match, clearing timer on
   // a stale count equal to duty must not kill the pulse at its start
   assign pulse_end = mode_pwm && (func == ptm_pkg::FUNC_3) && match_a && !on_rise;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         on_from_pin <= 1'b0;
      end else begin
         on_from_pin <= mode_pwm && (func == ptm_pkg::FUNC_3) && !timer_on && !cap_src && ed.rise;
      end
   end

   assign timer_output_pin_out = mode_tmr ? 1'b0 : (pin_level ^ invert);
   assign timer_output_pin_oe  = ~mode_tmr & ~mode_cap;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count         <= ptm_pkg::VALUE_RESET;
         timer_on_last <= 1'b0;
         out_level     <= 1'b0;
      end else begin
         count         <= next_count;
         timer_on_last <= timer_on;
         out_level     <= next_out_level;
      end
   end

   // capture latches the count into the duty register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl0                     <= ptm_pkg::CTRL0_RESET;
         timer_mode_output_control <= ptm_pkg::CTRL1_RESET;
         duty_compare_value        <= ptm_pkg::VALUE_RESET;
         period_compare_value      <= ptm_pkg::VALUE_RESET;
      end else begin
         if (wr && addr == ptm_pkg::ADDR_CTRL0) begin
            ctrl0 <= {wdata[7:3], 3'h0};
         end else if (pulse_end) begin
            ctrl0[ptm_pkg::TIMER_ON_BIT] <= 1'b0;
         end else if (on_from_pin) begin
            ctrl0[ptm_pkg::TIMER_ON_BIT] <= 1'b1;
         end
         if (wr && addr == ptm_pkg::ADDR_CTRL1) begin
            timer_mode_output_control <= wdata;
         end
         if (mode_cap && timer_on && ed.capture) begin
            duty_compare_value <= count;
         end else if (wr && addr == ptm_pkg::ADDR_DUTY_LO) begin
            duty_compare_value[7:0] <= wdata;
         end else if (wr && addr == ptm_pkg::ADDR_DUTY_HI) begin
            duty_compare_value[9:8] <= wdata[1:0];
         end
         if (wr && addr == ptm_pkg::ADDR_PER_LO) begin
            period_compare_value[7:0] <= wdata;
         end else if (wr && addr == ptm_pkg::ADDR_PER_HI) begin
            period_compare_value[9:8] <= wdata[1:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata <= 8'h00;
      end else if (rd) begin
         case (addr)
            ptm_pkg::ADDR_CTRL0:   rdata <= ctrl0;
            ptm_pkg::ADDR_CTRL1:   rdata <= timer_mode_output_control;
            ptm_pkg::ADDR_CNT_LO:  rdata <= count[7:0];
            ptm_pkg::ADDR_CNT_HI:  rdata <= {6'h00, count[9:8]};
            ptm_pkg::ADDR_DUTY_LO: rdata <= duty_compare_value[7:0];
            ptm_pkg::ADDR_DUTY_HI: rdata <= {6'h00, duty_compare_value[9:8]};
            ptm_pkg::ADDR_PER_LO:  rdata <= period_compare_value[7:0];
            default:               rdata <= {6'h00, period_compare_value[9:8]};
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   a_start_clears: assert property (@(posedge clk) disable iff (!rst_n)
      on_rise |=> count == 10'h000) else $error("counter not zero after start");
   a_off_holds: assert property (@(posedge clk) disable iff (!rst_n)
      !timer_on && !on_rise |=> $stable(count)) else $error("counter moved while off");
   a_init_level: assert property (@(posedge clk) disable iff (!rst_n)
      on_rise |=> out_level == $past(level_cfg)) else $error("initial level not restored");
   // pin not driven in timer mode
   a_timer_no_drive: assert property (@(posedge clk) disable iff (!rst_n)
      mode_tmr |-> !timer_output_pin_oe) else $error("pin driven in timer mode");
   a_cmp_toggle: assert property (@(posedge clk) disable iff (!rst_n)
      mode_cmp && match_a && !on_rise && func == 2'h3 |=> out_level != $past(out_level))
      else $error("toggle missed");
   a_cmp_low: assert property (@(posedge clk) disable iff (!rst_n)
      mode_cmp && match_a && !on_rise && func == 2'h1 |=> !out_level) else $error("low missed");
   a_invert_pin: assert property (@(posedge clk) disable iff (!rst_n)
      mode_pwm && func == 2'h1 |-> timer_output_pin_out == (level_cfg ^ invert))
      else $error("active level or invert wrong");
   a_overflow_zero: assert property (@(posedge clk) disable iff (!rst_n)
      mode_cmp && !clr_sel && period_compare_value != 10'h000 && !on_rise
      |-> !clear_cnt || match_p) else $error("overflow clear with nonzero period");
   a_clear_duty: assert property (@(posedge clk) disable iff (!rst_n)
      mode_cmp && clr_sel && match_a && !on_rise |=> count == 10'h000) else $error("no clear on duty match");
   a_capture_store: assert property (@(posedge clk) disable iff (!rst_n)
      mode_cap && timer_on && ed.capture |=> duty_compare_value == $past(count)) else $error("capture lost");

   a_cap_no_drive: assert property (@(posedge clk) disable iff (!rst_n)
      mode_cap |-> !timer_output_pin_oe) else $error("pin driven in capture mode");

   a_cmp_drive: assert property (@(posedge clk) disable iff (!rst_n)
      mode_cmp |-> timer_output_pin_oe) else $error("pin not driven in compare mode");

   a_pwm_inactive: assert property (@(posedge clk) disable iff (!rst_n)
      mode_pwm && func == ptm_pkg::FUNC_0 |-> timer_output_pin_out == (~level_cfg ^ invert))
      else $error("inactive level wrong");

   a_pwm_active: assert property (@(posedge clk) disable iff (!rst_n)
      mode_pwm && func == ptm_pkg::FUNC_2 && timer_on && count < duty_compare_value
      |-> timer_output_pin_out == (level_cfg ^ invert)) else $error("pwm active part wrong");

   a_cmp_high: assert property (@(posedge clk) disable iff (!rst_n)
      mode_cmp && match_a && !on_rise && func == ptm_pkg::FUNC_2 |=> out_level) else $error("high missed");

   a_cmp_hold: assert property (@(posedge clk) disable iff (!rst_n)
      mode_cmp && !on_rise && func == ptm_pkg::FUNC_0 |=> $stable(out_level)) else $error("level moved");

   a_cmp_pin: assert property (@(posedge clk) disable iff (!rst_n)
      mode_cmp |-> timer_output_pin_out == (out_level ^ invert)) else $error("compare pin wrong");

   a_timer_pin_low: assert property (@(posedge clk) disable iff (!rst_n)
      mode_tmr |-> !timer_output_pin_out) else $error("pin active in timer mode");

   a_clear_period: assert property (@(posedge clk) disable iff (!rst_n)
      mode_cmp && !clr_sel && match_p && !on_rise |=> count == 10'h000) else $error("no clear on period match");

   a_pwm_period: assert property (@(posedge clk) disable iff (!rst_n)
      mode_pwm && match_p && !on_rise |=> count == 10'h000) else $error("pwm period not cleared");

   a_pwm_no_duty: assert property (@(posedge clk) disable iff (!rst_n)
      mode_pwm && func == ptm_pkg::FUNC_2 && clr_sel && match_a && !match_p && !on_rise && count != 10'h3ff
      |=> count != 10'h000) else $error("pwm cleared on duty match");

   a_count_step: assert property (@(posedge clk) disable iff (!rst_n)
      timer_on && !paused && !on_rise && !clear_cnt |=> count == $past(count) + 10'h001)
      else $error("counter step wrong");

   a_pause_holds: assert property (@(posedge clk) disable iff (!rst_n)
      timer_on && paused && !on_rise |=> $stable(count)) else $error("counter moved while paused");

   a_pulse_stop: assert property (@(posedge clk) disable iff (!rst_n)
      pulse_end && !(wr && addr == ptm_pkg::ADDR_CTRL0) |=> !timer_on) else $error("pulse not ended");

   a_cap_disabled: assert property (@(posedge clk) disable iff (!rst_n)
      func == ptm_pkg::FUNC_3 |-> !ed.capture) else $error("capture while disabled");

   a_cap_src_tck: assert property (@(posedge clk) disable iff (!rst_n)
      cap_src |-> cap_pin == timer_clock_pin) else $error("capture source wrong");

   // pin released when timer mode set
   a_timer_release: assert property (@(posedge clk) disable iff (!rst_n)
      mode_tmr && timer_on |-> !timer_output_pin_oe && !timer_output_pin_out) else $error("pin used in timer mode");

   c_capture: cover property (@(posedge clk) mode_cap && ed.capture);
   c_pwm_run: cover property (@(posedge clk) mode_pwm && func == 2'h2 && match_p);
   c_toggle: cover property (@(posedge clk) mode_cmp && match_a && func == 2'h3);
   c_pulse_end: cover property (@(posedge clk) pulse_end);
endmodule // periodic_timer_mode_control

//--- rtl/ptm_pkg.sv
package ptm_pkg;
   localparam int CNT_W = 10;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 3;
   // register byte addresses
   localparam logic [2:0] ADDR_CTRL0 = 3'h0;
   localparam logic [2:0] ADDR_CTRL1 = 3'h1;
   localparam logic [2:0] ADDR_CNT_LO = 3'h2;
   localparam logic [2:0] ADDR_CNT_HI = 3'h3;
   localparam logic [2:0] ADDR_DUTY_LO = 3'h4;
   localparam logic [2:0] ADDR_DUTY_HI = 3'h5;
   localparam logic [2:0] ADDR_PER_LO = 3'h6;
   localparam logic [2:0] ADDR_PER_HI = 3'h7;
   // control0 fields
   localparam int TIMER_ON_BIT = 3;
   localparam int PAUSE_BIT = 7;
   // control1 fields
   localparam int MODE_HI_BIT = 7;
   localparam int MODE_LO_BIT = 6;
   localparam int FUNC_HI_BIT = 5;
   localparam int FUNC_LO_BIT = 4;
   localparam int LEVEL_BIT = 3;
   localparam int INVERT_BIT = 2;
   localparam int CAPSRC_BIT = 1;
   localparam int CLRSEL_BIT = 0;
   localparam logic [7:0] CTRL0_RESET = 8'h00;
   localparam logic [7:0] CTRL1_RESET = 8'h00;
   localparam logic [9:0] VALUE_RESET = 10'h000;
   // modes
   localparam logic [1:0] MODE_COMPARE = 2'h0;
   localparam logic [1:0] MODE_CAPTURE = 2'h1;
   localparam logic [1:0] MODE_PWM = 2'h2;
   localparam logic [1:0] MODE_TIMER = 2'h3;
   // output function codes
   localparam logic [1:0] FUNC_0 = 2'h0;
   localparam logic [1:0] FUNC_1 = 2'h1;
   localparam logic [1:0] FUNC_2 = 2'h2;
   localparam logic [1:0] FUNC_3 = 2'h3;
endpackage

//--- tb/periodic_timer_mode_control_tb.sv
`timescale 1ns/1ps
module periodic_timer_mode_control_tb;
   logic       clk;
   logic       rst_n;
   logic [2:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       pin_out;
   logic       pin_oe;
   logic       tp_lvl;
   logic       tck_lvl;
   logic       tp_wire;
   logic       tck_wire;
   int         n_mismatch;
   int         n_compared;

   periodic_timer_mode_control dut (
      .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .timer_output_pin_in(tp_wire), .timer_output_pin_out(pin_out), .timer_output_pin_oe(pin_oe),
      .timer_clock_pin(tck_wire));
   pin_model pins (.out(pin_out), .oe(pin_oe), .tp_level(tp_lvl), .tck_level(tck_lvl),
      .tp_wire(tp_wire), .tck_wire(tck_wire));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic chk(input string what, input logic [9:0] lo, input logic [9:0] hi, input logic [9:0] got);
      n_compared++;
      if (!(got >= lo && got <= hi) || $isunknown(got)) begin
         n_mismatch++;
         $display("Error %s expected %0d..%0d seen %h", what, lo, hi, got);
      end
   endtask

   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic cfg(input logic [7:0] c1, input logic [7:0] duty, input logic [7:0] per);
      wr_reg(ptm_pkg::ADDR_CTRL0, 8'h00);
      wr_reg(ptm_pkg::ADDR_CTRL1, c1);
      wr_reg(ptm_pkg::ADDR_DUTY_LO, duty);
      wr_reg(ptm_pkg::ADDR_DUTY_HI, 8'h00);
      wr_reg(ptm_pkg::ADDR_PER_LO, per);
      wr_reg(ptm_pkg::ADDR_PER_HI, 8'h00);
   endtask

   task automatic t_reset;
      logic [7:0] d;
      rd_reg(ptm_pkg::ADDR_CTRL1, d);
      chk("ctrl1 reset", 10'h000, 10'h000, {2'h0, d});
      chk("oe reset", 10'h001, 10'h001, {9'h000, pin_oe});
      chk("pin reset", 10'h000, 10'h000, {9'h000, pin_out});
   endtask

   task automatic t_timer_mode;
      cfg(8'hcc, 8'h05, 8'h00);
      wr_reg(ptm_pkg::ADDR_CTRL0, 8'h08);
      repeat (10) @(posedge clk);
      chk("oe timer mode", 10'h000, 10'h000, {9'h000, pin_oe});
      chk("pin timer mode", 10'h000, 10'h000, {9'h000, pin_out});
   endtask

   task automatic t_match;
      logic       l;
      logic [1:0] f;
      logic       e;
      for (int i = 0; i < 16; i++) begin
         f = i[1:0];
         l = i[2];
         e = (f == 2'h0) ? l : (f == 2'h1) ? 1'b0 : (f == 2'h2) ? 1'b1 : ~l;
         cfg({2'h0, f, l, i[3], 2'h0}, 8'h05, 8'h00);
         wr_reg(ptm_pkg::ADDR_CTRL0, 8'h08);
         repeat (20) @(posedge clk);
         #1;
         chk("pin after match", {9'h000, e ^ i[3]}, {9'h000, e ^ i[3]}, {9'h000, pin_out});
         wr_reg(ptm_pkg::ADDR_CTRL0, 8'h00);
         wr_reg(ptm_pkg::ADDR_CTRL0, 8'h08);
         @(posedge clk);
         #1;
         chk("pin after restart", {9'h000, l ^ i[3]}, {9'h000, l ^ i[3]}, {9'h000, pin_out});
      end
   endtask

   task automatic t_pwm;
      int         hi;
      logic [7:0] d;
      logic [9:0] lo_b [4] = '{10'd0, 10'd16, 10'd7, 10'd3};
      logic [9:0] hi_b [4] = '{10'd0, 10'd16, 10'd9, 10'd5};
      for (int f = 0; f < 4; f++) begin
         hi = 0;
         cfg({2'h2, f[1:0], 4'h9}, 8'h04, 8'h08);
         wr_reg(ptm_pkg::ADDR_CTRL0, 8'h08);
         repeat (16) begin
            @(posedge clk);
            #1 if (pin_out === 1'b1) hi++;
         end
         chk("pwm active cycles", lo_b[f], hi_b[f], hi[9:0]);
      end
      rd_reg(ptm_pkg::ADDR_CTRL0, d);
      chk("single pulse on bit", 10'h000, 10'h000, {9'h000, d[3]});
   endtask

   task automatic t_capture;
      logic [5:0] c;
      logic [7:0] d;
      logic [5:0] tbl [7] = '{6'h03, 6'h00, 6'h11, 6'h21, 6'h32, 6'h0f, 6'h0a};
      for (int i = 0; i < 7; i++) begin
         c = tbl[i];
         cfg({2'h1, c[5:4], 2'h0, c[3], 1'b0}, 8'hff, 8'h00);
         tp_lvl  <= ~c[1];
         tck_lvl <= ~c[1];
         repeat (6) @(posedge clk);
         wr_reg(ptm_pkg::ADDR_DUTY_HI, 8'h03);
         wr_reg(ptm_pkg::ADDR_CTRL0, 8'h08);
         chk("oe capture mode", 10'h000, 10'h000, {9'h000, pin_oe});
         if (c[2]) tck_lvl <= c[1];
         else tp_lvl <= c[1];
         repeat (10) @(posedge clk);
         rd_reg(ptm_pkg::ADDR_DUTY_HI, d);
         chk("captured high byte", c[0] ? 10'h000 : 10'h003, c[0] ? 10'h000 : 10'h003, {2'h0, d});
      end
   endtask

   task automatic t_clear;
      logic [7:0] d;
      logic [7:0] mx;
      logic [7:0] a;
      for (int c = 0; c < 2; c++) begin
         mx = 8'h00;
         cfg({7'h00, c[0]}, 8'h03, 8'h06);
         wr_reg(ptm_pkg::ADDR_CTRL0, 8'h08);
         repeat (24) begin
            rd_reg(ptm_pkg::ADDR_CNT_LO, d);
            if (d > mx) mx = d;
         end
         chk("count ceiling", c ? 10'd2 : 10'd5, c ? 10'd3 : 10'd6, {2'h0, mx});
         wr_reg(ptm_pkg::ADDR_CTRL0, 8'h00);
         rd_reg(ptm_pkg::ADDR_CNT_LO, a);
         repeat (5) @(posedge clk);
         rd_reg(ptm_pkg::ADDR_CNT_LO, d);
         chk("count held when off", {2'h0, a}, {2'h0, a}, {2'h0, d});
      end
   endtask

   task automatic give_verdict;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      give_verdict();
   end

   initial begin
      n_mismatch = 0;
      n_compared = 0;
      rst_n      = 1'b0;
      addr       = 3'h0;
      wdata      = 8'h00;
      wr         = 1'b0;
      rd         = 1'b0;
      tp_lvl     = 1'b0;
      tck_lvl    = 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_timer_mode();
      t_match();
      t_pwm();
      t_capture();
      t_clear();
      give_verdict();
   end
endmodule // periodic_timer_mode_control_tb

//--- tb/pin_model.sv
`timescale 1ns/1ps
module pin_model (
   input  wire logic out,
   input  wire logic oe,
   input  wire logic tp_level,
   input  wire logic tck_level,
   output logic      tp_wire,
   output logic      tck_wire
);
   // the device wins the shared pin only while it drives it
   assign tp_wire  = oe ? out : tp_level;
   assign tck_wire = tck_level;
endmodule // pin_model
